// ### hw/stp_pkg.sv
// stp_pkg: constants shared by the standard timer pwm / single-pulse block
// assumes: one sys_clk domain, plain register port with one-cycle read latency
package stp_pkg;

  // register offsets on the plain register port
  localparam logic [3:0] ADDR_CTRL0  = 4'h0;  // counter_run
  localparam logic [3:0] ADDR_CTRL1  = 4'h1;  // timer_control_one
  localparam logic [3:0] ADDR_CMPP   = 4'h2;  // compare_p_value
  localparam logic [3:0] ADDR_CMPA_L = 4'h3;  // compare_a_value low byte
  localparam logic [3:0] ADDR_CMPA_H = 4'h4;  // compare_a_value high byte
  localparam logic [3:0] ADDR_CNT_L  = 4'h5;  // counter low byte, read only
  localparam logic [3:0] ADDR_CNT_H  = 4'h6;  // counter high byte, read only
  localparam logic [3:0] ADDR_STAT   = 4'h7;  // match flags, write one to clear

  // field positions in timer_control_one, counter_run and the status register
  localparam int CTL1_MODE_HI   = 7;
  localparam int CTL1_MODE_LO   = 6;
  localparam int CTL1_PIN_HI    = 5;
  localparam int CTL1_PIN_LO    = 4;
  localparam int CTL1_LEVEL     = 3;
  localparam int CTL1_INVERT    = 2;
  localparam int CTL1_SWAP      = 1;
  localparam int CTL1_CLR_SRC   = 0;
  localparam int CTRL0_RUN      = 3;
  localparam int STAT_MATCH_A   = 0;
  localparam int STAT_MATCH_P   = 1;

  // reset values
  localparam logic [7:0]  CTRL1_RST = 8'h00;
  localparam logic [7:0]  CMPP_RST  = 8'h00;
  localparam logic [15:0] CMPA_RST  = 16'h0000;
  localparam logic [15:0] CNT_RST   = 16'h0000;

  // operating_mode_select / pin_action_select codes
  localparam logic [1:0] MODE_PWM     = 2'h2;
  localparam logic [1:0] PIN_INACTIVE = 2'h0;
  localparam logic [1:0] PIN_ACTIVE   = 2'h1;
  localparam logic [1:0] PIN_PWM      = 2'h2;
  localparam logic [1:0] PIN_SINGLE   = 2'h3;

  // synchroniser depth for the external pin
  localparam int SYNC_STAGES = 2;

endpackage : stp_pkg

// ### hw/stp_edge_if.sv
// stp_edge_if: carries the synchronised trigger pin edge from the input stage to the core
// assumes: both ends run on sys_clk
interface stp_edge_if;
  logic rise;   // one-cycle pulse on a low-to-high pin change
  logic level;  // synchronised pin level
  modport src (output rise, output level);
  modport dst (input rise, input level);
endinterface : stp_edge_if

// ### hw/stp_pin_sync.sv
// stp_pin_sync: two-flop synchroniser and edge detector for ext_clock_pin
// assumes: pin is asynchronous to sys_clk; reset asynchronous, active high
module stp_pin_sync (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic ext_clock_pin,
  stp_edge_if.src   edge_o
);

  // synchroniser plus one stage of history for edge detection
  typedef struct packed {
    logic s1;    // first sync flop, read only by s2
    logic s2;    // second sync flop
    logic prev;  // previous synchronised level
    logic rise;  // registered edge pulse
  } stp_sync_t;

  stp_sync_t sync_ff;
  stp_sync_t nxt_sync;

  // next state: shift pin in, detect rising edge on stable copies
  always_comb begin
    nxt_sync      = sync_ff;
    nxt_sync.s1   = ext_clock_pin;
    nxt_sync.s2   = sync_ff.s1;
    nxt_sync.prev = sync_ff.s2;
    nxt_sync.rise = sync_ff.s2 & ~sync_ff.prev;
  end

  // state register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync_ff <= '0;
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  assign edge_o.rise  = sync_ff.rise;
  assign edge_o.level = sync_ff.s2;

endmodule : stp_pin_sync

// ### hw/stp_timer.sv
// stp_timer: 16-bit standard timer, pwm output and single-pulse output modes
// assumes: sys_clk is the selected timer clock; registers over a plain port
//
// Summary of operation
// [RQ1] swap set: period compare_a, duty compare_p times 256
// [RQ2] pwm counter cleared by period match
// [RQ3] pwm counting continues with forced pin levels
// [RQ4] clear_source_select ignored in pwm mode
// [RQ5] single pulse when mode 10, pins 11
// [RQ6] counter_run rise starts counter, leading edge
// [RQ7] trigger pin edge sets counter_run
// [RQ8] counter_run low gives trailing edge
// [RQ9] compare_a match clears counter_run, stops counter
// [RQ10] compare_a match raises match_a_flag
// [RQ11] single pulse counter zeroed only on restart
// [RQ12] single pulse ignores compare_p, clear select, swap
// [RQ13] software keeps pin_action_select at 11
// [RQ14] software holds counter_run during the pulse
// [RQ15] duty not below period gives full duty
// [RQ16] compare_p matches counter upper eight bits
// [RQ17] counter_run rise restores initial pin level
// [RQ18] level control sets polarity, invert reverses (code ignores invert in single-pulse mode)
// [RQ19] active from clear until duty match
module stp_timer (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        ext_clock_pin,
  output logic             timer_out,
  output logic             match_a_irq,
  output logic             match_p_irq
);

  stp_edge_if trig_if ();  // synchronised trigger pin

  // trigger pin synchroniser
  stp_pin_sync i_stp_pin_sync (
    .sys_clk       (sys_clk),
    .reset         (reset),
    .ext_clock_pin (ext_clock_pin),
    .edge_o        (trig_if.src)
  );

  // all block state
  typedef struct packed {
    logic        counter_run;      // run bit
    logic        run_prev;         // run bit one cycle back
    logic [7:0]  ctrl1;            // timer_control_one
    logic [7:0]  cmp_p;            // compare_p_value
    logic [15:0] cmp_a;            // compare_a_value
    logic [15:0] count;            // up counter
    logic        wave;             // internal waveform, 1 = active
    logic        pulse;            // single-pulse level, 1 = active
    logic        flag_a;           // match_a_flag
    logic        flag_p;           // compare_p match flag
    logic        pin;              // driven output pin
    logic [7:0]  rdata;            // read data
  } stp_state_t;

  stp_state_t st_ff;
  stp_state_t nxt_st;

  // comparator-p match on counter upper bits, zero means overflow
  // taken on the last count below p x 256, so the span is p x 256 clocks
  function automatic logic p_match(input logic [7:0] p, input logic [15:0] c);
    if (p == 8'h00) begin
      p_match = (c == 16'hFFFF);
    end else begin
      p_match = (c[15:8] == p - 8'h01) && (c[7:0] == 8'hFF);  // RQ16
    end
  endfunction : p_match

  // comparator-a match, all sixteen bits, zero means overflow
  function automatic logic a_match(input logic [15:0] a, input logic [15:0] c);
    if (a == 16'h0000) begin
      a_match = (c == 16'hFFFF);
    end else begin
      a_match = (c == a - 16'h0001);
    end
  endfunction : a_match

  // decoded control fields
  logic [1:0] mode_sel;   // operating_mode_select
  logic [1:0] pin_sel;    // pin_action_select
  logic       lvl_ctl;    // output_level_control
  logic       inv;        // output_invert
  logic       swap;       // duty_period_swap
  logic       single;     // single-pulse mode active
  logic       run_rise;   // counter_run low-to-high this cycle
  logic       hit_a;      // comparator-a match at this count
  logic       hit_p;      // comparator-p match at this count
  logic       per_hit;    // period match in pwm mode
  logic       duty_hit;   // duty match in pwm mode
  logic       duty_full;  // duty at or beyond period
  logic [16:0] duty_len;  // duty length in clocks
  logic [16:0] per_len;   // period length in clocks
  logic       act_lvl;    // waveform level before polarity
  logic       pin_lvl;    // pin level

  always_comb begin
    mode_sel = {st_ff.ctrl1[stp_pkg::CTL1_MODE_HI], st_ff.ctrl1[stp_pkg::CTL1_MODE_LO]};
    pin_sel  = {st_ff.ctrl1[stp_pkg::CTL1_PIN_HI], st_ff.ctrl1[stp_pkg::CTL1_PIN_LO]};
    lvl_ctl  = st_ff.ctrl1[stp_pkg::CTL1_LEVEL];
    inv      = st_ff.ctrl1[stp_pkg::CTL1_INVERT];
    swap     = st_ff.ctrl1[stp_pkg::CTL1_SWAP];
    single   = (mode_sel == stp_pkg::MODE_PWM) && (pin_sel == stp_pkg::PIN_SINGLE);  // RQ5
    run_rise = st_ff.counter_run & ~st_ff.run_prev;
    hit_a    = a_match(st_ff.cmp_a, st_ff.count);
    hit_p    = p_match(st_ff.cmp_p, st_ff.count);
    // lengths in clocks; zero values mean the full 65536 range
    duty_len = (st_ff.cmp_p == 8'h00) ? 17'h10000 : {1'b0, st_ff.cmp_p, 8'h00};
    per_len  = (st_ff.cmp_a == 16'h0000) ? 17'h10000 : {1'b0, st_ff.cmp_a};
    if (!swap) begin
      duty_len = (st_ff.cmp_a == 16'h0000) ? 17'h10000 : {1'b0, st_ff.cmp_a};
      per_len  = (st_ff.cmp_p == 8'h00) ? 17'h10000 : {1'b0, st_ff.cmp_p, 8'h00};
    end
    // period source picked by swap only, clear select ignored
    per_hit   = swap ? hit_a : hit_p;  // RQ2 RQ4
    duty_hit  = swap ? hit_p : hit_a;  // RQ1
    duty_full = (duty_len >= per_len);  // RQ15
    act_lvl   = single ? st_ff.pulse : st_ff.wave;
    // polarity: level control picks active level, invert reverses pwm
    pin_lvl   = lvl_ctl ? act_lvl : ~act_lvl;  // RQ18
    if (!single && inv) begin
      pin_lvl = ~pin_lvl;  // RQ18
    end
  end

  // next-state logic
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.run_prev = st_ff.counter_run;
    nxt_st.rdata    = 8'h00;

    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        stp_pkg::ADDR_CTRL0:  nxt_st.counter_run = reg_wdata[stp_pkg::CTRL0_RUN];
        stp_pkg::ADDR_CTRL1:  nxt_st.ctrl1 = reg_wdata;
        stp_pkg::ADDR_CMPP:   nxt_st.cmp_p = reg_wdata;
        stp_pkg::ADDR_CMPA_L: nxt_st.cmp_a[7:0] = reg_wdata;
        stp_pkg::ADDR_CMPA_H: nxt_st.cmp_a[15:8] = reg_wdata;
        stp_pkg::ADDR_STAT: begin
          if (reg_wdata[stp_pkg::STAT_MATCH_A]) begin
            nxt_st.flag_a = 1'b0;
          end
          if (reg_wdata[stp_pkg::STAT_MATCH_P]) begin
            nxt_st.flag_p = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // trigger pin edge sets the run bit in single-pulse mode
    if (single && trig_if.rise) begin
      nxt_st.counter_run = 1'b1;  // RQ7
    end

    if (run_rise) begin
      // restart: counter zeroed, pin back to initial state
      nxt_st.count = stp_pkg::CNT_RST;  // RQ6 RQ11
      nxt_st.wave  = 1'b1;               // RQ17 RQ19
      nxt_st.pulse = 1'b1;               // RQ6 RQ17
    end else if (st_ff.counter_run) begin
      if (single) begin
        // single pulse: only comparator a matters
        nxt_st.count = st_ff.count + 16'h0001;  // RQ12
        if (hit_a) begin
          nxt_st.counter_run = 1'b0;  // RQ9
          nxt_st.pulse       = 1'b0;  // RQ9
          nxt_st.flag_a      = 1'b1;  // RQ10
        end
      end else begin
        // pwm: counting runs whatever pin_action_select forces
        if (per_hit) begin
          nxt_st.count = stp_pkg::CNT_RST;  // RQ2 RQ3
          nxt_st.wave  = 1'b1;               // RQ19
        end else begin
          nxt_st.count = st_ff.count + 16'h0001;
          if (duty_hit && !duty_full) begin
            nxt_st.wave = 1'b0;  // RQ19
          end
        end
        if (hit_a) begin
          nxt_st.flag_a = 1'b1;
        end
        if (hit_p) begin
          nxt_st.flag_p = 1'b1;
        end
      end
    end

    // run bit low ends the pulse at once
    if (!nxt_st.counter_run) begin
      nxt_st.pulse = 1'b0;  // RQ8
    end

    // pin drive by pin_action_select
    unique case (pin_sel)
      stp_pkg::PIN_INACTIVE: nxt_st.pin = ~lvl_ctl ^ (inv & ~single);  // RQ3
      stp_pkg::PIN_ACTIVE:   nxt_st.pin = lvl_ctl ^ (inv & ~single);   // RQ3
      stp_pkg::PIN_PWM:      nxt_st.pin = pin_lvl;
      stp_pkg::PIN_SINGLE:   nxt_st.pin = pin_lvl;
    endcase
    if (mode_sel != stp_pkg::MODE_PWM) begin
      nxt_st.pin = 1'b0;
    end

    // register reads, data shown next cycle
    if (reg_rd) begin
      unique case (reg_addr)
        stp_pkg::ADDR_CTRL0:  nxt_st.rdata = {4'h0, st_ff.counter_run, 3'h0};
        stp_pkg::ADDR_CTRL1:  nxt_st.rdata = st_ff.ctrl1;
        stp_pkg::ADDR_CMPP:   nxt_st.rdata = st_ff.cmp_p;
        stp_pkg::ADDR_CMPA_L: nxt_st.rdata = st_ff.cmp_a[7:0];
        stp_pkg::ADDR_CMPA_H: nxt_st.rdata = st_ff.cmp_a[15:8];
        stp_pkg::ADDR_CNT_L:  nxt_st.rdata = st_ff.count[7:0];
        stp_pkg::ADDR_CNT_H:  nxt_st.rdata = st_ff.count[15:8];
        stp_pkg::ADDR_STAT:   nxt_st.rdata = {6'h00, st_ff.flag_p, st_ff.flag_a};
        default:              nxt_st.rdata = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_ff       <= '0;
      st_ff.ctrl1 <= stp_pkg::CTRL1_RST;
      st_ff.cmp_p <= stp_pkg::CMPP_RST;
      st_ff.cmp_a <= stp_pkg::CMPA_RST;
      st_ff.count <= stp_pkg::CNT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign reg_rdata   = st_ff.rdata;
  assign timer_out   = st_ff.pin;
  assign match_a_irq = st_ff.flag_a;
  assign match_p_irq = st_ff.flag_p;

endmodule : stp_timer

// ### tb/stp_timer_props.sv
// stp_timer_props: port-level checks of the pwm / single-pulse timer
// assumes: bound to stp_timer, one sys_clk domain
module stp_timer_props (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       ext_clock_pin,
  input wire logic       timer_out,
  input wire logic       match_a_irq,
  input wire logic       match_p_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ctl_ff;  // shadow of timer_control_one
  logic [1:0] age_ff;  // cycles since its last write
  wire        sp   = ctl_ff[7:6] == stp_pkg::MODE_PWM && ctl_ff[5:4] == stp_pkg::PIN_SINGLE;
  wire        calm = age_ff == 2'h3;          // setting has settled
  wire        idle = timer_out == !ctl_ff[3];  // pulse pin inactive
  // follow control writes, saturating age
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctl_ff <= stp_pkg::CTRL1_RST;
      age_ff <= 2'h3;
    end else if (reg_wr && reg_addr == stp_pkg::ADDR_CTRL1) begin
      ctl_ff <= reg_wdata;
      age_ff <= 2'h0;
    end else if (!calm) begin
      age_ff <= age_ff + 2'h1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  a_stat_read: assert property (reg_rd && reg_addr == stp_pkg::ADDR_STAT |=>
    reg_rdata[1:0] == {$past(match_p_irq), $past(match_a_irq)}) else $error("status read wrong");
  a_flag_a_hold: assert property (match_a_irq && !(reg_wr && reg_addr == stp_pkg::ADDR_STAT
    && reg_wdata[0]) |=> match_a_irq) else $error("match flag lost");
  a_mode_off_low: assert property (calm && ctl_ff[7:6] != stp_pkg::MODE_PWM |-> !timer_out)
    else $error("pin driven outside waveform mode");
  a_force_level: assert property (calm && ctl_ff[7:6] == stp_pkg::MODE_PWM && !ctl_ff[5] |->
    timer_out == ((ctl_ff[4] ~^ ctl_ff[3]) ^ ctl_ff[2])) else $error("forced level wrong");
  a_pulse_match: assert property (calm && sp && $rose(match_a_irq) |-> ##[0:3] idle)
    else $error("pulse outlives match");
  a_pulse_sw_end: assert property (calm && sp && reg_wr && reg_addr == stp_pkg::ADDR_CTRL0
    && !reg_wdata[3] |-> ##[1:3] idle) else $error("pulse outlives stop");
  a_pin_start: assert property (calm && sp && idle && $rose(ext_clock_pin) |-> ##[2:8] !idle)
    else $error("pin edge gave no pulse");
endmodule : stp_timer_props

// ### tb/stp_pin_model.sv
// stp_pin_model: far side of the timer, trigger pin driver and output meter
// assumes: shares sys_clk with the timer; bench drives fire and clr
module stp_pin_model (
  input  wire logic sys_clk,
  input  wire logic fire,       // request one trigger pulse
  input  wire logic clr,        // restart the meter
  input  wire logic timer_out,  // waveform pin
  output logic      ext_clock_pin,
  output integer    width       // cycles seen high, unknown stays unknown
);
  timeunit 1ns;
  timeprecision 1ns;
  int hold = 0;  // trigger cycles left
  initial ext_clock_pin = 1'b0;
  initial width = 0;
  // pin idles low, rises for four cycles per request
  always @(posedge sys_clk) begin
    hold          <= fire ? 4 : (hold > 0 ? hold - 1 : 0);
    ext_clock_pin <= fire || hold > 1;
    width         <= clr ? 0 : width + 32'(timer_out);
  end
endmodule : stp_pin_model

// ### tb/stp_timer_tb.sv
// stp_timer_tb: self-checking bench for the pwm / single-pulse timer
// assumes: design, pin model and checker compiled before it
module stp_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk = 1'b0;
  logic       reset   = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       ext_clock_pin;
  logic       timer_out;
  logic       match_a_irq;
  logic       match_p_irq;
  logic       fire = 1'b0;  // trigger request
  logic       clr  = 1'b0;  // meter restart
  integer     width;        // high cycles metered
  int         num_errors = 0;
  int         check_count = 0;
  always #25 sys_clk = ~sys_clk;
  stp_timer i_stp_timer (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clock_pin(ext_clock_pin),
    .timer_out(timer_out), .match_a_irq(match_a_irq), .match_p_irq(match_p_irq));
  stp_pin_model i_stp_pin_model (.sys_clk(sys_clk), .fire(fire), .clr(clr), .timer_out(timer_out),
    .ext_clock_pin(ext_clock_pin), .width(width));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read, then compare the byte against exp under mask m
  task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(what, {8'h00, reg_rdata & m}, {8'h00, exp});
  endtask : rchk
  task automatic meter;
    @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
  endtask : meter
  // bounded wait for the pulse to come and go
  task automatic wait_end;
    int i;
    for (i = 0; i < 2000; i++) begin
      // look between edges, where pin and meter have settled
      @(negedge sys_clk);
      if (width > 0 && timer_out === 1'b0) break;
    end
    if (i == 2000) begin
      num_errors++;
      end_of_test;
    end
  endtask : wait_end
  // stopped while pin action changes
  task automatic cfg(input logic [7:0] c1, input logic [7:0] ca);
    wr(stp_pkg::ADDR_CTRL0, 8'h00);
    wr(stp_pkg::ADDR_CTRL1, c1);
    wr(stp_pkg::ADDR_CMPA_L, ca);
    wr(stp_pkg::ADDR_CMPP, 8'h01);
    wr(stp_pkg::ADDR_STAT, 8'h03);
  endtask : cfg
  task automatic shot(input logic by_pin, input int lo, input int hi);
    meter;
    if (by_pin) begin
      fire <= 1'b1;
      @(posedge sys_clk);
      fire <= 1'b0;
    end else begin
      wr(stp_pkg::ADDR_CTRL0, 8'h08);
    end
    wait_end;
    chk("pulse width", {15'h0000, width >= lo && width <= hi}, 16'h0001);
  endtask : shot
  // period 256 with duty 64, or period 100 with full duty, polarity, forced levels
  task automatic s_pwm;
    logic [7:0]  c1 [7] = '{8'hA8, 8'hAC, 8'hA0, 8'hA9, 8'hAA, 8'h88, 8'h98};
    logic [15:0] ex [7] = '{16'h0080, 16'h0180, 16'h0180, 16'h0080, 16'h0200, 16'h0000, 16'h0200};
    for (int k = 0; k < 7; k++) begin
      cfg(c1[k], k == 4 ? 8'h64 : 8'h40);
      wr(stp_pkg::ADDR_CTRL0, 8'h08);
      repeat (8) @(posedge sys_clk);
      meter;
      repeat (512) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("pwm active cycles", 16'(width), ex[k]);
      rchk("period flag", stp_pkg::ADDR_STAT, 8'h02, {6'h00, !c1[k][1], 1'b0});
    end
  endtask : s_pwm
  task automatic s_pulse;
    cfg(8'hB8, 8'h14);
    shot(1'b0, 20, 21);
    rchk("match flag", stp_pkg::ADDR_STAT, 8'h01, 8'h01);
    rchk("run bit", stp_pkg::ADDR_CTRL0, 8'h08, 8'h00);
    rchk("stopped count", stp_pkg::ADDR_CNT_L, 8'hFF, 8'h14);
    cfg(8'hBB, 8'h14);
    shot(1'b0, 20, 21);
    cfg(8'hB8, 8'h14);
    shot(1'b1, 20, 21);
    cfg(8'hB8, 8'hC8);
    meter;
    wr(stp_pkg::ADDR_CTRL0, 8'h08);
    repeat (30) @(posedge sys_clk);
    wr(stp_pkg::ADDR_CTRL0, 8'h00);
    wait_end;
    chk("stopped width", {15'h0000, width < 40}, 16'h0001);
    shot(1'b0, 200, 201);
  endtask : s_pulse
  // ctrl1 reset value, a read-back and an unmapped address
  task automatic s_regs;
    rchk("ctrl1 reset", stp_pkg::ADDR_CTRL1, 8'hFF, stp_pkg::CTRL1_RST);
    wr(stp_pkg::ADDR_CMPA_H, 8'h5A);
    rchk("cmpa high", stp_pkg::ADDR_CMPA_H, 8'hFF, 8'h5A);
    wr(stp_pkg::ADDR_CMPA_H, 8'h00);
    wr(4'h9, 8'hFF);
    rchk("unmapped", 4'h9, 8'hFF, 8'h00);
  endtask : s_regs
  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    s_regs;
    s_pwm;
    s_pulse;
    end_of_test;
  end
endmodule : stp_timer_tb
bind stp_timer stp_timer_props i_stp_timer_props (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ext_clock_pin(ext_clock_pin), .timer_out(timer_out), .match_a_irq(match_a_irq), .match_p_irq(match_p_irq));
